// ---- rtl/halfband_interp_pkg.sv ----
// Constants, coefficient sets and types for the interpolation chain.
// Assumes a single 40 MHz system clock; no software registers.
package halfband_interp_pkg;

    // ****************************************************************
    // Widths and timing
    // ****************************************************************
    localparam int          DATA_W_DEF   = 16;
    localparam int          ACC_W_DEF    = 40;
    localparam int          CNT_W        = 3;
    localparam logic [2:0]  CNT_RESET    = 3'h0;
    localparam logic [1:0]  RST_SYNC_INI = 2'h0;

    // ****************************************************************
    // Ratio encodings (log2 of the interpolation ratio)
    // ****************************************************************
    typedef enum logic [1:0] {
        RATIO_1 = 2'h0,
        RATIO_2 = 2'h1,
        RATIO_4 = 2'h2,
        RATIO_8 = 2'h3
    } ratio_t;

    // ****************************************************************
    // Filter geometry and output scaling
    // ****************************************************************
    localparam int LPF1_TAPS   = 55;
    localparam int LPF2_TAPS   = 23;
    localparam int LPF3_TAPS   = 15;
    localparam int ISINC_TAPS  = 9;
    localparam int LPF1_SHIFT  = 15;
    localparam int LPF2_SHIFT  = 12;
    localparam int LPF3_SHIFT  = 13;
    localparam int ISINC_SHIFT = 9;

    // ****************************************************************
    // Coefficients, index 0 is the outermost tap
    // ****************************************************************
    localparam int LPF1_COEF [LPF1_TAPS] = '{
        -4, 0, 13, 0, -34, 0, 72, 0, -138, 0, 245, 0, -408, 0,
        650, 0, -1003, 0, 1521, 0, -2315, 0, 3671, 0, -6642, 0, 20755,
        32768,
        20755, 0, -6642, 0, 3671, 0, -2315, 0, 1521, 0, -1003, 0, 650,
        0, -408, 0, 245, 0, -138, 0, 72, 0, -34, 0, 13, 0, -4};
    localparam int LPF2_COEF [LPF2_TAPS] = '{
        -2, 0, 17, 0, -75, 0, 238, 0, -660, 0, 2530, 4096,
        2530, 0, -660, 0, 238, 0, -75, 0, 17, 0, -2};
    localparam int LPF3_COEF [LPF3_TAPS] = '{
        -39, 0, 273, 0, -1102, 0, 4964, 8192, 4964, 0, -1102, 0, 273, 0, -39};
    localparam int ISINC_COEF [ISINC_TAPS] = '{
        2, -4, 10, -35, 401, -35, 10, -4, 2};

endpackage

// ---- rtl/halfband_interp_chain.sv ----
// Dual-path half-band interpolation chain with inverse-sinc correction.
// Assumes the sample source runs on clk_sys and watches inReady.
//
// Function
// - Interpolate up to eight times per channel
// - All filter stages can be bypassed
// - First stage: symmetric 55-tap half-band filter
// - Second stage: symmetric 23-tap half-band filter
// - Third stage: symmetric 15-tap half-band filter
// - Inverse-sinc stage: symmetric 9-tap, centre 401
// - I on first port, Q second; identical
`timescale 1ns/10ps

// ********************************************************************
// One FIR stage, optionally zero-stuffing
// ********************************************************************
module interp_fir_stage
    import halfband_interp_pkg::*;
#(
    parameter int TAPS          = LPF3_TAPS,
    parameter int COEF [TAPS]   = '{default: 0},
    parameter int SHIFT         = LPF3_SHIFT,
    parameter int DATA_W        = DATA_W_DEF,
    parameter int ACC_W         = ACC_W_DEF,
    parameter bit UPSAMPLE      = 1'b1
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rstN,
    input  wire logic                     strobe,
    input  wire logic                     zeroIns,
    input  wire logic signed [DATA_W-1:0] dataIn,
    output logic signed [DATA_W-1:0]      dataOut
);
    localparam int C = (TAPS - 1) / 2;

    logic signed [DATA_W-1:0] lineReg [TAPS];
    logic signed [ACC_W-1:0]  acc;
    logic signed [ACC_W-1:0]  scaled;
    logic signed [DATA_W-1:0] satNext;

    // Zero samples pad the stream to twice the rate
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < TAPS; i++) begin
                lineReg[i] <= '0;
            end
        end else if (strobe) begin
            lineReg[0] <= (UPSAMPLE && zeroIns) ? '0 : dataIn;
            for (int i = 1; i < TAPS; i++) begin
                lineReg[i] <= lineReg[i-1];
            end
        end
    end

    // Constant multipliers; zero taps fold away in synthesis
    always_comb begin
        acc = '0;
        for (int i = 0; i < TAPS; i++) begin
            acc = acc + ACC_W'(COEF[i]) * ACC_W'(lineReg[i]);
        end
    end

    // Saturate rather than wrap if the source runs too hot
    always_comb begin
        scaled = acc >>> SHIFT;
        if (scaled > ACC_W'(signed'({1'b0, {(DATA_W-1){1'b1}}}))) begin
            satNext = {1'b0, {(DATA_W-1){1'b1}}};
        end else if (scaled < ACC_W'(signed'({1'b1, {(DATA_W-1){1'b0}}}))) begin
            satNext = {1'b1, {(DATA_W-1){1'b0}}};
        end else begin
            satNext = scaled[DATA_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            dataOut <= '0;
        end else if (strobe) begin
            dataOut <= satNext;
        end
    end

    // Half-band: after a zero insert only the centre tap sees data
    if (UPSAMPLE) begin : g_check
        a_centre_pass:
        assert property (@(posedge clk_sys) disable iff (!rstN)
            (strobe && zeroIns) |=> (acc == (ACC_W'(lineReg[C]) <<< SHIFT)))
        else $error("half-band output is not the centre sample");
    end

endmodule // interp_fir_stage

// ********************************************************************
// Top: input capture, rate sequencing, two identical paths
// ********************************************************************
module halfband_interp_chain
    import halfband_interp_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF
) (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic [1:0]        ratioSel,
    input  wire logic              isincEn,
    input  wire logic              inValid,
    output logic                   inReady,
    input  wire logic [DATA_W-1:0] inI,
    input  wire logic [DATA_W-1:0] inQ,
    output logic                   outValid,
    output logic [DATA_W-1:0]      outI,
    output logic [DATA_W-1:0]      outQ
);
    logic [1:0]       rstPipe;
    logic             rstSyncN;
    logic             runReg;
    ratio_t           ratioReg;
    logic             isincReg;
    logic [CNT_W-1:0] cntReg;
    logic [3:1]       strobe;
    logic [3:1]       zeroIns;
    logic             sameReg;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstPipe <= RST_SYNC_INI;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe[1];

    // Mode is caught once after reset; changing it live would skew phases
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            runReg   <= 1'b0;
            ratioReg <= RATIO_1;
            isincReg <= 1'b0;
        end else if (!runReg) begin
            runReg   <= 1'b1;
            ratioReg <= ratio_t'(ratioSel);
            isincReg <= isincEn;
        end
    end

    // ****************************************************************
    // Rate sequencing
    // ****************************************************************
    function automatic logic [CNT_W-1:0] lowMask(input logic [1:0] k);
        unique case (k)
            2'h0:    lowMask = 3'h0;
            2'h1:    lowMask = 3'h1;
            2'h2:    lowMask = 3'h3;
            default: lowMask = 3'h7;
        endcase
    endfunction

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cntReg <= CNT_RESET;
        end else if (runReg) begin
            cntReg <= cntReg + 3'h1;
        end
    end

    // One input per ratio cycles; ratio 1 means every cycle
    assign inReady = runReg && ((cntReg & lowMask(ratioReg)) == 3'h0);

    // Stage s runs at 2^s times the input rate
    always_comb begin
        for (int s = 1; s <= 3; s++) begin
            strobe[s]  = 1'b0;
            zeroIns[s] = 1'b0;
            if (runReg && (2'(s) <= ratioReg)) begin
                strobe[s]  = (cntReg & lowMask(2'(ratioReg - 2'(s)))) == 3'h0;
                zeroIns[s] = cntReg[2'(ratioReg - 2'(s))];
            end
        end
    end

    // ****************************************************************
    // Two paths, same sequencing
    // ****************************************************************
    for (genvar ch = 0; ch < 2; ch++) begin : g_path
        logic signed [DATA_W-1:0] inReg;
        logic signed [DATA_W-1:0] stOut [1:3];
        logic signed [DATA_W-1:0] link  [1:4];
        logic signed [DATA_W-1:0] sincOut;
        logic        [DATA_W-1:0] outReg;

        // Starved input becomes silence rather than a repeat
        always_ff @(posedge clk_sys or negedge rstSyncN) begin
            if (!rstSyncN) begin
                inReg <= '0;
            end else if (inReady) begin
                inReg <= !inValid ? '0 : (ch == 0) ? inI : inQ;
            end
        end

        assign link[1] = inReg;
        assign link[2] = (ratioReg >= RATIO_2) ? stOut[1] : link[1];
        assign link[3] = (ratioReg >= RATIO_4) ? stOut[2] : link[2];
        assign link[4] = (ratioReg >= RATIO_8) ? stOut[3] : link[3];

        interp_fir_stage #(.TAPS(LPF1_TAPS), .COEF(LPF1_COEF), .SHIFT(LPF1_SHIFT),
                           .DATA_W(DATA_W), .UPSAMPLE(1'b1)) u_lpf1 (
            .clk_sys(clk_sys), .rstN(rstSyncN), .strobe(strobe[1]), .zeroIns(zeroIns[1]),
            .dataIn(link[1]), .dataOut(stOut[1]));
        interp_fir_stage #(.TAPS(LPF2_TAPS), .COEF(LPF2_COEF), .SHIFT(LPF2_SHIFT),
                           .DATA_W(DATA_W), .UPSAMPLE(1'b1)) u_lpf2 (
            .clk_sys(clk_sys), .rstN(rstSyncN), .strobe(strobe[2]), .zeroIns(zeroIns[2]),
            .dataIn(link[2]), .dataOut(stOut[2]));
        interp_fir_stage #(.TAPS(LPF3_TAPS), .COEF(LPF3_COEF), .SHIFT(LPF3_SHIFT),
                           .DATA_W(DATA_W), .UPSAMPLE(1'b1)) u_lpf3 (
            .clk_sys(clk_sys), .rstN(rstSyncN), .strobe(strobe[3]), .zeroIns(zeroIns[3]),
            .dataIn(link[3]), .dataOut(stOut[3]));
        // Correction runs at the output rate, every cycle
        interp_fir_stage #(.TAPS(ISINC_TAPS), .COEF(ISINC_COEF), .SHIFT(ISINC_SHIFT),
                           .DATA_W(DATA_W), .UPSAMPLE(1'b0)) u_isinc (
            .clk_sys(clk_sys), .rstN(rstSyncN), .strobe(runReg), .zeroIns(1'b0),
            .dataIn(link[4]), .dataOut(sincOut));

        always_ff @(posedge clk_sys or negedge rstSyncN) begin
            if (!rstSyncN) begin
                outReg <= '0;
            end else begin
                outReg <= isincReg ? sincOut : link[4];
            end
        end
    end

    assign outI = g_path[0].outReg;
    assign outQ = g_path[1].outReg;

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            outValid <= 1'b0;
        end else begin
            outValid <= runReg;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Tracks whether every accepted I sample matched its Q sample
    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            sameReg <= 1'b1;
        end else if (inReady && inValid && (inI != inQ)) begin
            sameReg <= 1'b0;
        end
    end

    a_ratio_eight:
    assert property (@(posedge clk_sys) disable iff (!rstSyncN)
        (ratioReg == RATIO_8 && inReady) |=> (!inReady)[*7] ##1 inReady)
    else $error("8x mode does not take one input per eight cycles");
    a_ratio_two:
    assert property (@(posedge clk_sys) disable iff (!rstSyncN)
        (ratioReg == RATIO_2 && inReady) |=> !inReady ##1 inReady)
    else $error("2x mode does not take one input per two cycles");
    a_bypass_ready:
    assert property (@(posedge clk_sys) disable iff (!rstSyncN)
        (runReg && ratioReg == RATIO_1) |-> inReady && !strobe[1] && !strobe[2])
    else $error("bypass mode is not passing every sample");
    a_paths_equal:
    assert property (@(posedge clk_sys) disable iff (!rstSyncN)
        sameReg |-> (outI == outQ))
    else $error("I and Q paths differ for equal inputs");
    a_lpf1_taps:
    assert property (@(posedge clk_sys) disable iff (!rstSyncN)
        1'b1 |-> (LPF1_COEF[0] == -4 && LPF1_COEF[27] == 32768
                  && LPF1_COEF[26] == 20755 && LPF1_COEF[28] == 20755
                  && LPF1_COEF[54] == -4 && LPF1_COEF[1] == 0))
    else $error("first stage taps are wrong");
    a_lpf2_taps:
    assert property (@(posedge clk_sys) disable iff (!rstSyncN)
        1'b1 |-> (LPF2_COEF[11] == 4096 && LPF2_COEF[10] == 2530
                  && LPF2_COEF[0] == -2 && LPF2_COEF[22] == -2 && LPF2_COEF[9] == 0))
    else $error("second stage taps are wrong");
    a_lpf3_taps:
    assert property (@(posedge clk_sys) disable iff (!rstSyncN)
        1'b1 |-> (LPF3_COEF[7] == 8192 && LPF3_COEF[6] == 4964
                  && LPF3_COEF[0] == -39 && LPF3_COEF[14] == -39 && LPF3_COEF[5] == 0))
    else $error("third stage taps are wrong");
    a_isinc_taps:
    assert property (@(posedge clk_sys) disable iff (!rstSyncN)
        1'b1 |-> (ISINC_COEF[4] == 401 && ISINC_COEF[3] == -35
                  && ISINC_COEF[0] == 2 && ISINC_COEF[8] == 2 && ISINC_COEF[1] == -4))
    else $error("inverse-sinc taps are wrong");
endmodule // halfband_interp_chain

// ---- tb/baseband_source.sv ----
// Baseband sample source model for the interpolation chain.
// Assumes inReady is sampled on rising clk_sys; drives on the falling edge.
`timescale 1ns/10ps

module baseband_source (
    input  wire logic   clk_sys,
    input  wire logic   inReady,
    output logic        inValid,
    output logic [15:0] inI,
    output logic [15:0] inQ
);
    // ****************************************************************
    // Queue of pending pairs
    // ****************************************************************
    localparam int PEAK = 32729;
    logic [15:0] qI [$];
    logic [15:0] qQ [$];
    logic        took;

    // Backs off about 0.01 dB so filter sums cannot overflow
    function automatic logic [15:0] clip(input logic signed [15:0] v);
        if (v > PEAK) return 16'(PEAK);
        if (v < -PEAK) return 16'(-PEAK);
        return v;
    endfunction

    task automatic push(input logic [15:0] i, input logic [15:0] q);
        qI.push_back(clip(i));
        qQ.push_back(clip(q));
    endtask

    task automatic flush();
        qI = {};
        qQ = {};
    endtask

    initial begin
        took = 1'b0;
        inValid = 1'b0;
        inI = 16'h0000;
        inQ = 16'h0000;
    end

    always @(posedge clk_sys) begin
        took <= inReady && inValid;
    end

    // ****************************************************************
    // Drive: hold a pair until taken
    // ****************************************************************
    always @(negedge clk_sys) begin
        if (took && qI.size() > 0) begin
            qI.delete(0);
            qQ.delete(0);
        end
        if (qI.size() > 0) begin
            inValid <= 1'b1;
            inI     <= qI[0];
            inQ     <= qQ[0];
        end else begin
            // Released lines toggle so stale data is never mistaken for valid
            inValid <= 1'b0;
            inI     <= ~inI;
            inQ     <= ~inQ;
        end
    end
endmodule // baseband_source

// ---- tb/testbench.sv ----
// Self-checking bench: impulse responses of every ratio and the inverse-sinc.
// Assumes the chain captures its mode once after each reset release.
`timescale 1ns/10ps

module testbench;
    import halfband_interp_pkg::*;

    localparam int TAPS [4]   = '{LPF1_TAPS, LPF2_TAPS, LPF3_TAPS, ISINC_TAPS};
    localparam int SHIFTS [4] = '{LPF1_SHIFT, LPF2_SHIFT, LPF3_SHIFT, ISINC_SHIFT};
    logic        clk_sys;
    logic        resetn;
    logic [1:0]  ratioSel;
    logic        isincEn;
    logic        inValid;
    logic        inReady;
    logic [15:0] inI;
    logic [15:0] inQ;
    logic        outValid;
    logic [15:0] outI;
    logic [15:0] outQ;
    int          nMismatch;
    int          checksDone;

    halfband_interp_chain DUT (.clk_sys(clk_sys), .resetn(resetn), .ratioSel(ratioSel),
        .isincEn(isincEn), .inValid(inValid), .inReady(inReady), .inI(inI), .inQ(inQ),
        .outValid(outValid), .outI(outI), .outQ(outQ));
    baseband_source src (.clk_sys(clk_sys), .inReady(inReady), .inValid(inValid),
        .inI(inI), .inQ(inQ));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // Compare and report
    // ****************************************************************
    task automatic checkVal(input string what, input int exp, input logic [15:0] seen,
                            input int tol);
        logic signed [31:0] diff;
        diff = $signed(seen) - exp;
        checksDone++;
        if ((diff <= tol && diff >= -tol) !== 1'b1) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, $signed(seen));
        end
    endtask

    task automatic checkBit(input string what, input logic exp, input logic seen);
        checksDone++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************************************
    // Reference cascade: zero-stuff, convolve, shift, saturate
    // ****************************************************************
    function automatic int stageCoef(input int s, input int i);
        if (i < 0 || i >= TAPS[s-1]) return 0;
        case (s)
            1: return LPF1_COEF[i];
            2: return LPF2_COEF[i];
            3: return LPF3_COEF[i];
            default: return ISINC_COEF[i];
        endcase
    endfunction

    task automatic model(input int ratio, input bit isinc, input int amp, output int y[$]);
        int     x[$];
        longint acc;
        int     step;
        y = {amp};
        for (int s = 1; s <= 4; s++) begin
            if (s <= ratio || (s == 4 && isinc)) begin
                x = y;
                y = {};
                step = (s == 4) ? 1 : 2;
                for (int n = 0; n < step * (x.size() - 1) + TAPS[s-1]; n++) begin
                    acc = 0;
                    foreach (x[k]) acc += longint'(x[k]) * stageCoef(s, n - step * k);
                    acc = acc >>> SHIFTS[s-1];
                    y.push_back(int'((acc > 32767) ? 32767 : (acc < -32768) ? -32768 : acc));
                end
            end
        end
        repeat (4) begin
            y.push_front(0);
            y.push_back(0);
        end
    endtask

    // ****************************************************************
    // Shared run: reset into a mode, send one impulse, judge the output
    // ****************************************************************
    task automatic impulseRun(input logic [1:0] ratio, input logic isinc, input int amp,
                              input int tol);
        int          eI[$];
        int          eQ[$];
        logic [15:0] oI[$];
        logic [15:0] oQ[$];
        int          rdy;
        int          pe;
        int          po;
        @(negedge clk_sys);
        resetn = 1'b0;
        ratioSel = ratio;
        isincEn = isinc;
        src.flush();
        repeat (10) @(negedge clk_sys);
        checkBit("inReady in reset", 1'b0, inReady);
        checkBit("outValid in reset", 1'b0, outValid);
        checkVal("outI in reset", 0, outI, 0);
        resetn = 1'b1;
        src.push(16'(amp), 16'(-amp));
        rdy = 0;
        for (int c = 0; c < 400; c++) begin
            @(negedge clk_sys);
            if (c >= 8 && c < 72 && inReady === 1'b1) rdy++;
            oI.push_back(outI);
            oQ.push_back(outQ);
        end
        checkVal("inReady count", 64 >> ratio, 16'(rdy), 0);
        checkBit("outValid running", 1'b1, outValid);
        model(ratio, isinc, amp, eI);
        model(ratio, isinc, -amp, eQ);
        pe = 0;
        po = 0;
        foreach (eI[i]) if (eI[i] > eI[pe]) pe = i;
        foreach (oI[i]) if ($signed(oI[i]) > $signed(oI[po])) po = i;
        foreach (eI[i]) begin
            checkVal("outI", eI[i], oI[po - pe + i], tol);
            checkVal("outQ", eQ[i], oQ[po - pe + i], tol);
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic testBypass();
        impulseRun(2'h0, 1'b0, 16'h3039, 0);
    endtask

    task automatic testInvSinc();
        impulseRun(2'h0, 1'b1, 16'h0200, 1);
    endtask

    task automatic testRatio2();
        impulseRun(2'h1, 1'b0, 16'h4000, 1);
    endtask

    task automatic testRatio4();
        impulseRun(2'h2, 1'b0, 16'h4000, 3);
    endtask

    task automatic testRatio8();
        impulseRun(2'h3, 1'b0, 16'h4000, 4);
    endtask

    // Six runs of about 420 cycles each; generous margin
    initial begin
        #200000;
        nMismatch++;
        tallyAndFinish();
    end

    initial begin
        resetn = 1'b0;
        ratioSel = 2'h0;
        isincEn = 1'b0;
        nMismatch = 0;
        checksDone = 0;
        testBypass();
        testInvSinc();
        testRatio2();
        testRatio4();
        testRatio8();
        testBypass();
        tallyAndFinish();
    end
endmodule // testbench
